// ---- design/edge_sync.sv ----
// two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// asynchronous level and its synchronised edge
	input wire logic async_in,
	output logic rise_out
);
	logic s1_r, s2_r, s3_r;
	logic s1_nxt, s2_nxt, s3_nxt;
	// next values; only s2 reads s1
	always_comb begin
		s1_nxt = async_in;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end
	// registers
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end
	assign rise_out = s2_r & ~s3_r;
endmodule
`default_nettype wire

// ---- design/pilot_pkg.sv ----
// package: constants and carrier types for the pilot pwm block
package pilot_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_160_000;
	localparam int unsigned PILOT_HZ = 1_000;
	localparam int unsigned METER_HZ = 4_000;
	localparam int unsigned PERIOD_COUNTS = CLK_HZ / PILOT_HZ;
	localparam int unsigned METER_COUNTS = CLK_HZ / METER_HZ;
	localparam int unsigned CNT_W = 15;
	localparam logic [CNT_W-1:0] PERIOD_LAST = 15'(PERIOD_COUNTS - 1);
	localparam logic [CNT_W-1:0] METER_LAST = 15'(METER_COUNTS - 1);
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic PILOT_RST = 1'b1;
	localparam logic [CNT_W-1:0] DUTY_RST = 15'h0000;
	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic pwm_enable;
		logic gf_irq_enable;
		logic duty_load;
		logic [CNT_W-1:0] duty;
	} pilot_ctrl_s;
	typedef struct packed {
		logic pilot;
		logic gf_irq;
		logic meter_irq;
		logic sar_trigger;
	} pilot_stat_s;
	typedef enum logic [1:0] {
		TRG_IDLE = 2'b00,
		TRG_BUSY = 2'b01,
		TRG_FIRE = 2'b11
	} trig_state_e;
endpackage

// ---- design/pilot_pwm.sv ----
// pilot pwm generator, ground-fault interrupt and pilot sample trigger
// Behaviour
// - pilot carries continuous 1 kHz pwm whenever driving is enabled
// - one compare sets period, a second compare sets high time
// - counter runs at 25.16 MHz and wraps after 25160 counts
// - duty compare is a fraction of the period, loaded into a shadow and applied at the period wrap
// - after reset and before enable, pilot output is held high
// - counter runs from start; pwm reaches pin only once enabled
// - ground-fault edge raises interrupt only when enabled, default off
// - metering interrupt occurs at 4 kHz, four per pilot period
// - sar conversion starts only on trigger after metering work completes
`timescale 1ns/1ps
`default_nettype none
module pilot_pwm
	import pilot_pkg::*;
#(
	parameter logic [CNT_W-1:0] PERIOD_LAST_P = PERIOD_LAST,
	parameter logic [CNT_W-1:0] METER_LAST_P = METER_LAST
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// control from the charging state machine
	input wire pilot_ctrl_s ctrl_in,
	// metering processing done, same clock
	input wire logic meter_done_in,
	// ground-fault sense pin
	input wire logic gf_pin_in,
	// outputs
	output var pilot_stat_s stat_out
);
	// ------------------------------------------------------------
	// period counter and compares
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [CNT_W-1:0] duty_r, duty_nxt;
	logic [CNT_W-1:0] shadow_r, shadow_nxt;
	logic pend_r, pend_nxt;
	logic en_r, en_nxt;
	logic pilot_r, pilot_nxt;
	logic wrap;
	assign wrap = (cnt_r == PERIOD_LAST_P);
	// counter, shadowed duty, pilot level
	always_comb begin
		cnt_nxt = wrap ? '0 : cnt_r + 15'h0001;
		shadow_nxt = shadow_r;
		pend_nxt = pend_r;
		duty_nxt = duty_r;
		en_nxt = en_r;
		if (ctrl_in.duty_load) begin
			shadow_nxt = ctrl_in.duty;
			pend_nxt = 1'b1;
		end
		if (wrap) begin
			if (pend_r && !ctrl_in.duty_load) begin
				duty_nxt = shadow_r;
				pend_nxt = 1'b0;
			end
			en_nxt = ctrl_in.pwm_enable; // start on boundary
		end
		if (!ctrl_in.pwm_enable)
			en_nxt = 1'b0;
		if (en_nxt)
			pilot_nxt = (cnt_nxt < duty_nxt);
		else
			pilot_nxt = 1'b1;
	end
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			cnt_r <= '0;
			duty_r <= DUTY_RST;
			shadow_r <= DUTY_RST;
			pend_r <= 1'b0;
			en_r <= 1'b0;
			pilot_r <= PILOT_RST;
		end else begin
			cnt_r <= cnt_nxt;
			duty_r <= duty_nxt;
			shadow_r <= shadow_nxt;
			pend_r <= pend_nxt;
			en_r <= en_nxt;
			pilot_r <= pilot_nxt;
		end
	end
	// ------------------------------------------------------------
	// ground-fault interrupt
	// ------------------------------------------------------------
	logic gf_rise;
	logic gf_irq_r, gf_irq_nxt;
	edge_sync u_gf_sync (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.async_in(gf_pin_in),
		.rise_out(gf_rise)
	);
	// one-cycle pulse on a gated rising edge
	always_comb begin
		gf_irq_nxt = gf_rise & ctrl_in.gf_irq_enable;
	end
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			gf_irq_r <= 1'b0;
		else
			gf_irq_r <= gf_irq_nxt;
	end
	// ------------------------------------------------------------
	// metering tick and sar trigger
	// ------------------------------------------------------------
	logic [CNT_W-1:0] mcnt_r, mcnt_nxt;
	logic mirq_r, mirq_nxt;
	logic trig_r, trig_nxt;
	trig_state_e st_r, st_nxt;
	// 4 kHz tick; trigger after processing done
	always_comb begin
		mirq_nxt = (mcnt_r == METER_LAST_P);
		mcnt_nxt = mirq_nxt ? '0 : mcnt_r + 15'h0001;
		st_nxt = st_r;
		trig_nxt = 1'b0;
		case (st_r)
			TRG_IDLE: begin
				if (mirq_r)
					st_nxt = TRG_BUSY;
			end
			TRG_BUSY: begin
				if (meter_done_in) begin
					st_nxt = TRG_FIRE;
					trig_nxt = 1'b1;
				end
			end
			TRG_FIRE: begin
				st_nxt = TRG_IDLE;
			end
			default: begin
				st_nxt = TRG_IDLE;
			end
		endcase
	end
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			mcnt_r <= '0;
			mirq_r <= 1'b0;
			trig_r <= 1'b0;
			st_r <= TRG_IDLE;
		end else begin
			mcnt_r <= mcnt_nxt;
			mirq_r <= mirq_nxt;
			trig_r <= trig_nxt;
			st_r <= st_nxt;
		end
	end
	// output bundle, one driver for the whole struct
	assign stat_out = {pilot_r, gf_irq_r, mirq_r, trig_r};
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	// pilot level and enable
	AST_IDLE_HIGH: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!en_r |-> stat_out.pilot)
		else $error("pilot not high while disabled");
	AST_DISABLE_HIGH: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!ctrl_in.pwm_enable |=> stat_out.pilot)
		else $error("pilot not high after pwm disable");
	// period counter
	AST_WRAP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		wrap |=> cnt_r == '0)
		else $error("period counter did not wrap");
	AST_COUNT: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!wrap |=> cnt_r == $past(cnt_r) + 15'h0001)
		else $error("period counter stalled");
	AST_HIGH_TIME: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		en_r |-> stat_out.pilot == (cnt_r < duty_r))
		else $error("pilot level disagrees with duty compare");
	// duty shadow and period-boundary update
	AST_DUTY_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!$past(wrap) |-> $stable(duty_r))
		else $error("duty changed inside a period");
	AST_DUTY_LOAD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ctrl_in.duty_load |=> shadow_r == $past(ctrl_in.duty))
		else $error("duty value not captured");
	AST_DUTY_APPLY: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		wrap && pend_r && !ctrl_in.duty_load |=> duty_r == $past(shadow_r))
		else $error("pending duty not applied at wrap");
	AST_PEND_CLEAR: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		wrap && pend_r && !ctrl_in.duty_load |=> !pend_r)
		else $error("pending flag not cleared at wrap");
	AST_ENABLE_EDGE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(en_r) |-> $past(wrap))
		else $error("pwm started mid period");
	// ground fault
	AST_GF_GATE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		stat_out.gf_irq |-> $past(ctrl_in.gf_irq_enable))
		else $error("ground-fault irq while disabled");
	AST_GF_PULSE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		stat_out.gf_irq |=> !stat_out.gf_irq)
		else $error("ground-fault irq longer than one cycle");
	// metering tick and trigger
	AST_METER_RATE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		mirq_r |=> !mirq_r [*3])
		else $error("metering tick too frequent");
	AST_METER_PERIOD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		mirq_r |-> mcnt_r == '0)
		else $error("metering tick off its count");
	AST_TRIG_CAUSE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		stat_out.sar_trigger |-> $past(meter_done_in) && $past(st_r) == TRG_BUSY)
		else $error("sar trigger without completed processing");
	AST_TRIG_ONCE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		stat_out.sar_trigger |=> !stat_out.sar_trigger)
		else $error("sar trigger longer than one cycle");
	// ------------------------------------------------------------
	// covers
	// ------------------------------------------------------------
	COV_PWM_ON: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(en_r));
	COV_DUTY_SWAP: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		wrap && pend_r);
	COV_GF: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		stat_out.gf_irq);
	COV_TRIG: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		stat_out.sar_trigger);
	COV_LOAD_AT_WRAP: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		wrap && ctrl_in.duty_load);
endmodule
`default_nettype wire

// ---- testbench/meter_model.sv ----
// metering processing model that answers each metering tick
`timescale 1ns/1ps
`default_nettype none
module meter_model (
	// clock
	input wire logic clock_in,
	// tick and processing time in cycles
	input wire logic meter_irq_in,
	input wire logic [3:0] delay_in,
	// processing done
	output logic meter_done_out
);
	logic [3:0] cnt_r = 4'h0;
	// count down the processing time after each tick
	always @(negedge clock_in) begin
		if (meter_irq_in) begin
			cnt_r <= delay_in;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
	assign meter_done_out = (cnt_r == 4'h1); // one-cycle done
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the pilot pwm block
`timescale 1ns/1ps
`default_nettype none
module tb_top import pilot_pkg::*;;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic gf_pin = 1'b0;
	logic meter_done;
	logic [3:0] dly = 4'h2;
	pilot_ctrl_s ctrl = '0;
	pilot_stat_s stat;
	int error_cnt = 0;
	int checked = 0;
	always #2.5 clock_in = ~clock_in;
	pilot_pwm #(.PERIOD_LAST_P(15'h0063), .METER_LAST_P(15'h0018)) dut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl),
		.meter_done_in(meter_done), .gf_pin_in(gf_pin), .stat_out(stat));
	meter_model far (.clock_in(clock_in), .meter_irq_in(stat.meter_irq),
		.delay_in(dly), .meter_done_out(meter_done));
	// -----------------------------------------------------------
	// helpers
	// -----------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	// wait until status bit idx turns to lvl; n cycles, h pilot highs
	task wait_edge(input int idx, input logic lvl, output int n,
		output int h);
		logic prev;
		n = 0;
		h = 0;
		do begin
			prev = stat[idx];
			cyc(1);
			n++;
			if (stat.pilot === 1'b1) h++;
			if (n > 300) begin
				error_cnt++;
				end_sim();
			end
		end while (!(stat[idx] === lvl && prev !== lvl));
	endtask
	// -----------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------
	task t_reset;
		cyc(10);
		chk(16'(stat), 16'h0008);
	endtask
	task t_pwm;
		int n, h;
		ctrl.duty = 15'h001E;
		ctrl.duty_load = 1'b1;
		cyc(1);
		ctrl.duty_load = 1'b0;
		ctrl.pwm_enable = 1'b1;
		wait_edge(3, 1'b0, n, h);
		wait_edge(3, 1'b0, n, h);
		chk(16'(n), 16'h0064);
		chk(16'(h), 16'h001E);
	endtask
	task t_reload;
		int n, h;
		ctrl.duty = 15'h003C;
		ctrl.duty_load = 1'b1;
		cyc(1);
		ctrl.duty_load = 1'b0;
		wait_edge(3, 1'b0, n, h);
		chk(16'(n), 16'h0081);
		chk(16'(h), 16'h003C);
	endtask
	task t_disable;
		ctrl.pwm_enable = 1'b0;
		cyc(1);
		chk(16'(stat.pilot), 16'h0001);
		cyc(150);
		chk(16'(stat.pilot), 16'h0001);
	endtask
	task t_gf;
		int c;
		c = 0;
		gf_pin = 1'b1;
		repeat (8) begin
			cyc(1);
			if (stat.gf_irq !== 1'b0) c++;
		end
		gf_pin = 1'b0;
		cyc(3);
		chk(16'(c), 16'h0000);
		ctrl.gf_irq_enable = 1'b1;
		gf_pin = 1'b1;
		cyc(3);
		chk(16'(stat.gf_irq), 16'h0001);
		cyc(1);
		chk(16'(stat.gf_irq), 16'h0000);
	endtask
	task t_meter(input logic [3:0] d);
		int n, h;
		dly = d;
		wait_edge(1, 1'b1, n, h);
		wait_edge(0, 1'b1, n, h);
		chk(16'(n), 16'(d));
		wait_edge(1, 1'b1, n, h);
		chk(16'(n), 16'h0019 - 16'(d));
	endtask
	// mid-run reset while pwm is enabled: pilot idles high, count restarts
	task t_rerun;
		int n, h;
		gf_pin = 1'b0;
		ctrl.pwm_enable = 1'b1;
		rst_n_in = 1'b0;
		cyc(2);
		rst_n_in = 1'b1;
		cyc(1);
		chk(16'(stat), 16'h0008);
		wait_edge(3, 1'b0, n, h);
		chk(16'(n), 16'h0063);
		chk(16'(h), 16'h0062);
	endtask
	initial begin
		cyc(4);
		rst_n_in = 1'b1;
		t_reset();
		t_pwm();
		t_reload();
		t_disable();
		t_gf();
		t_meter(4'h2);
		t_meter(4'h8);
		t_rerun();
		end_sim();
	end
endmodule
`default_nettype wire
